// ---- shared/gdwt_pkg.sv ----
/*
 * constants, state type and period table for the gpio-driven watchdog.
 * assumes a single 250 MHz clock and i/o-space register access.
 */
package gdwt_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_MHZ = 250;
	localparam int unsigned TICK_TIME_US = 1000;
	localparam int unsigned TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;
	localparam int unsigned RST_HOLD_CYCLES = 16;
	localparam int unsigned HOLD_W = 5;
	localparam int unsigned MS_W = 16;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int unsigned IO_AW = 16;
	localparam int unsigned CFG_AW = 8;
	localparam logic [CFG_AW-1:0] CFG_BASE_OFS = 8'h48;
	localparam logic [IO_AW-1:0] BASE_MASK = 16'hFF80;
	localparam logic [IO_AW-1:0] BANK_TWO_OFS = 16'h0038;
	localparam logic [IO_AW-1:0] BANK_THREE_OFS = 16'h0048;
	localparam logic [IO_AW-1:0] BASE_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ENABLE_N_BIT = 15;
	localparam int unsigned SEL_LSB = 0;
	localparam int unsigned SEL_W = 3;
	localparam int unsigned KICK_BIT = 7;
	localparam int unsigned LED_SEL0 = 0;
	localparam int unsigned LED_SEL1 = 1;
	localparam int unsigned LED_SEL2 = 2;
	localparam int unsigned LED_KICK = 7;
	localparam logic [31:0] BANK_TWO_RESET = 32'h0000_8000;
	localparam logic [31:0] BANK_THREE_RESET = 32'h0000_0000;
	localparam logic [SEL_W-1:0] SEL_OFF = 3'h7;

	// ----------------------------------------------------------------
	// timeout periods in milliseconds
	// ----------------------------------------------------------------
	localparam logic [MS_W-1:0] PERIOD0_MS = 16'h0020;
	localparam logic [MS_W-1:0] PERIOD1_MS = 16'h0080;
	localparam logic [MS_W-1:0] PERIOD2_MS = 16'h0200;
	localparam logic [MS_W-1:0] PERIOD3_MS = 16'h03E8;
	localparam logic [MS_W-1:0] PERIOD4_MS = 16'h0FA0;
	localparam logic [MS_W-1:0] PERIOD5_MS = 16'h1F40;
	localparam logic [MS_W-1:0] PERIOD6_MS = 16'h7D00;

	typedef enum logic [1:0] {
		GDWT_IDLE = 2'b00,
		GDWT_RUN = 2'b01,
		GDWT_FIRE = 2'b10
	} gdwt_state_t;

	// off code maps to the longest period; it is never used while off
	function automatic logic [MS_W-1:0] gdwt_period_ms(input logic [SEL_W-1:0] sel);
		case (sel)
			3'h0: gdwt_period_ms = PERIOD0_MS;
			3'h1: gdwt_period_ms = PERIOD1_MS;
			3'h2: gdwt_period_ms = PERIOD2_MS;
			3'h3: gdwt_period_ms = PERIOD3_MS;
			3'h4: gdwt_period_ms = PERIOD4_MS;
			3'h5: gdwt_period_ms = PERIOD5_MS;
			default: gdwt_period_ms = PERIOD6_MS;
		endcase
	endfunction

endpackage

// ---- hw/gdwt_tick_div.sv ----
/*
 * millisecond tick divider for the watchdog.
 * assumes clear_i restarts the phase so a period begins on a clean boundary.
 */
`timescale 1ns/1ps
module gdwt_tick_div #(
	parameter int unsigned CYCLES = gdwt_pkg::TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clear_i,
	output logic tick_o
);
	import gdwt_pkg::*;

	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	always_comb
	begin
		cnt_next = cnt_reg + 1'b1;
		tick_next = 1'b0;
		if (clear_i)
		begin
			cnt_next = '0;
		end
		else if (cnt_reg == LAST)
		begin
			cnt_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;

endmodule

// ---- hw/gdwt_top.sv ----
/*
 * watchdog timer steered by two gpio level registers in i/o space.
 * assumes single-cycle i/o and config strobes, synchronous to mclk_i.
 */
`timescale 1ns/1ps

//Function
//- seven selectable timeout periods, 32 ms shortest, 32 s longest
//- enabled watchdog whose period expires unserviced asserts system reset
//- active-low enable lives in bit 15 of bank two at base plus 0x38
//- enable bit resets to one, watchdog starts disabled
//- select bits occupy bits 0..2 of bank three at base plus 0x48
//- after self test LED0 shows inverted select bit 0
//- after self test LED1 shows inverted select bit 1
//- kick bit is bank three bit 7, inverted onto LED7 after self test
//- both 32-bit registers sit at a base held in config bytes 0x48-0x4B
//- clearing enable starts timing with the already chosen period
//- codes 000..110 give the seven periods; 111 or enable high disables
module gdwt_top #(
	parameter int unsigned TICK_CYCLES = gdwt_pkg::TICK_CYCLES,
	parameter int unsigned RST_HOLD = gdwt_pkg::RST_HOLD_CYCLES
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cfg_wr_i,
	input wire logic [gdwt_pkg::CFG_AW-1:0] cfg_addr_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [gdwt_pkg::IO_AW-1:0] io_addr_i,
	input wire logic [3:0] io_be_i,
	input wire logic [31:0] io_wdata_i,
	output logic [31:0] io_rdata_o,
	output logic io_ack_o,
	input wire logic post_done_i,
	input wire logic [7:0] post_code_i,
	output logic [7:0] led_o,
	output logic wdt_rst_o
);
	import gdwt_pkg::*;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [IO_AW-1:0] base_reg, base_next;
	logic [31:0] bank2_reg, bank2_next;
	logic [31:0] bank3_reg, bank3_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic hit2, hit3;

	assign hit2 = (io_addr_i == IO_AW'(base_reg + BANK_TWO_OFS));
	assign hit3 = (io_addr_i == IO_AW'(base_reg + BANK_THREE_OFS));

	always_comb
	begin
		base_next = base_reg;
		bank2_next = bank2_reg;
		bank3_next = bank3_reg;
		rdata_next = rdata_reg;
		ack_next = io_wr_i | io_rd_i;
		if (cfg_wr_i && cfg_addr_i == CFG_BASE_OFS)
			base_next = cfg_wdata_i[IO_AW-1:0] & BASE_MASK;
		for (int i = 0; i < 4; i++)
		begin
			if (io_wr_i && io_be_i[i] && hit2)
				bank2_next[8*i +: 8] = io_wdata_i[8*i +: 8];
			if (io_wr_i && io_be_i[i] && hit3)
				bank3_next[8*i +: 8] = io_wdata_i[8*i +: 8];
		end
		// unmapped reads answer zero
		if (io_rd_i)
			rdata_next = hit2 ? bank2_reg : (hit3 ? bank3_reg : 32'h0000_0000);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			base_reg <= BASE_RESET;
			bank2_reg <= BANK_TWO_RESET;
			bank3_reg <= BANK_THREE_RESET;
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end
		else
		begin
			base_reg <= base_next;
			bank2_reg <= bank2_next;
			bank3_reg <= bank3_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	// ----------------------------------------------------------------
	// watchdog core
	// ----------------------------------------------------------------
	gdwt_state_t state_reg, state_next;
	logic [MS_W-1:0] cnt_reg, cnt_next;
	logic [HOLD_W-1:0] hold_reg, hold_next;
	logic rst_reg, rst_next;
	logic kick_prev_reg;
	logic [SEL_W-1:0] sel;
	logic active, kick_toggle, tick, expire;

	assign sel = bank3_reg[SEL_LSB +: SEL_W];
	// off when enable high or code 111
	assign active = !bank2_reg[ENABLE_N_BIT] && (sel != SEL_OFF);
	// either edge of the kick bit
	assign kick_toggle = bank3_reg[KICK_BIT] ^ kick_prev_reg;
	assign expire = (state_reg == GDWT_RUN) && active && tick && !kick_toggle &&
		(cnt_reg == MS_W'(gdwt_period_ms(sel) - 1'b1));

	// phase restarts too, so a kick buys a full period, not a partial tick
	gdwt_tick_div #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i((state_reg != GDWT_RUN) || kick_toggle),
		.tick_o(tick)
	);

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		hold_next = hold_reg;
		rst_next = rst_reg;
		case (state_reg)
			GDWT_IDLE:
			begin
				cnt_next = '0;
				if (active)
					state_next = GDWT_RUN;
			end
			GDWT_RUN:
			begin
				if (!active)
				begin
					state_next = GDWT_IDLE;
					cnt_next = '0;
				end
				else if (kick_toggle)
					cnt_next = '0;
				else if (expire)
				begin
					state_next = GDWT_FIRE;
					cnt_next = '0;
					hold_next = '0;
					rst_next = 1'b1;
				end
				else if (tick)
					cnt_next = cnt_reg + 1'b1;
			end
			GDWT_FIRE:
			begin
				cnt_next = '0;
				if (hold_reg == HOLD_W'(RST_HOLD - 1))
				begin
					rst_next = 1'b0;
					state_next = GDWT_IDLE;
				end
				else
					hold_next = hold_reg + 1'b1;
			end
			default:
			begin
				state_next = GDWT_IDLE;
				cnt_next = '0;
				rst_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_reg <= GDWT_IDLE;
			cnt_reg <= '0;
			hold_reg <= '0;
			rst_reg <= 1'b0;
			kick_prev_reg <= BANK_THREE_RESET[KICK_BIT];
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hold_reg <= hold_next;
			rst_reg <= rst_next;
			kick_prev_reg <= bank3_reg[KICK_BIT];
		end
	end

	// ----------------------------------------------------------------
	// diagnostic leds
	// ----------------------------------------------------------------
	logic [7:0] led_reg, led_next;

	always_comb
	begin
		led_next = post_code_i;
		if (post_done_i)
		begin
			led_next[LED_SEL0] = !bank3_reg[SEL_LSB];
			led_next[LED_SEL1] = !bank3_reg[SEL_LSB + 1];
			led_next[LED_SEL2] = !bank3_reg[SEL_LSB + 2];
			led_next[LED_KICK] = !bank3_reg[KICK_BIT];
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			led_reg <= 8'h00;
		else
			led_reg <= led_next;
	end

	assign io_rdata_o = rdata_reg;
	assign io_ack_o = ack_reg;
	assign led_o = led_reg;
	assign wdt_rst_o = rst_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_rst_cause;
		$rose(wdt_rst_o) |-> $past(expire) && $past(cnt_reg) == MS_W'(gdwt_period_ms($past(sel)) - 1'b1);
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("reset without expiry");
	property p_disabled_quiet;
		bank2_reg[ENABLE_N_BIT] || sel == SEL_OFF |=> !$rose(wdt_rst_o);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("reset while off");
	property p_enable_reset;
		$past(sys_rst_i) |-> bank2_reg[ENABLE_N_BIT] && state_reg == GDWT_IDLE;
	endproperty
	a_enable_reset: assert property (p_enable_reset) else $error("enable not one");
	property p_enable_write;
		io_wr_i && hit2 && io_be_i[1] |=> bank2_reg[ENABLE_N_BIT] == $past(io_wdata_i[ENABLE_N_BIT]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");
	property p_sel_write;
		io_wr_i && hit3 && io_be_i[0] |=> sel == $past(io_wdata_i[SEL_LSB +: SEL_W]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select write lost");
	property p_led_inv;
		post_done_i |=> led_o[LED_SEL0] == !$past(bank3_reg[SEL_LSB]) &&
			led_o[LED_KICK] == !$past(bank3_reg[KICK_BIT]);
	endproperty
	a_led_inv: assert property (p_led_inv) else $error("led0 or led7 wrong");
	property p_led1_inv;
		post_done_i |=> led_o[LED_SEL1] == !$past(bank3_reg[SEL_LSB + 1]);
	endproperty
	a_led1_inv: assert property (p_led1_inv) else $error("led1 wrong");

	property p_kick_restart;
		state_reg == GDWT_RUN && active && kick_toggle |=> cnt_reg == '0 && !wdt_rst_o;
	endproperty
	a_kick_restart: assert property (p_kick_restart) else $error("kick not honoured");

	property p_off_clear;
		!active |=> cnt_reg == '0;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("counter runs while off");

	property p_start_run;
		state_reg == GDWT_IDLE && active |=> state_reg == GDWT_RUN;
	endproperty
	a_start_run: assert property (p_start_run) else $error("enable did not start");

	property p_stray_io;
		io_wr_i && !hit2 && !hit3 |=> $stable(bank2_reg) && $stable(bank3_reg);
	endproperty
	a_stray_io: assert property (p_stray_io) else $error("stray write landed");

endmodule

// ---- sim/gdwt_tb.sv ----
/*
 * self-checking bench for the gpio-driven watchdog top.
 * assumes a one-clock tick, so all seven periods fit the run budget.
 */
`timescale 1ns/1ps
module tb;
	import gdwt_pkg::*;
	localparam int TK = 1;
	localparam int LIMIT = 60000;
	localparam logic [15:0] A2 = 16'h01B8;
	localparam logic [15:0] A3 = 16'h01C8;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cfg_wr_i = 1'b0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [31:0] cfg_wdata_i = 32'h0;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [15:0] io_addr_i = 16'h0;
	logic [3:0] io_be_i = 4'hF;
	logic [31:0] io_wdata_i = 32'h0;
	logic [31:0] io_rdata_o;
	logic io_ack_o;
	logic post_done_i = 1'b0;
	logic [7:0] post_code_i = 8'h00;
	logic [7:0] led_o;
	logic wdt_rst_o;
	int err_count = 0;
	int n_tests = 0;
	int rst_cnt = 0;
	logic [31:0] rd;
	int per_ms [7] = '{32, 128, 512, 1000, 4000, 8000, 32000};

	always #2 mclk_i = ~mclk_i;

	gdwt_top #(.TICK_CYCLES(TK), .RST_HOLD(16)) dut_u (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i),
		.cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_be_i(io_be_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_ack_o(io_ack_o),
		.post_done_i(post_done_i), .post_code_i(post_code_i), .led_o(led_o),
		.wdt_rst_o(wdt_rst_o)
	);

	// ----------------------------------------------------------------
	// expiry watch: counts reset cycles, scenarios compare snapshots
	// ----------------------------------------------------------------
	always @(posedge mclk_i)
	begin
		if (wdt_rst_o === 1'b1)
			rst_cnt <= rst_cnt + 1;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ----------------------------------------------------------------
	// bus cycles: strobe one cycle, i/o ack expected right after it
	// ----------------------------------------------------------------
	task automatic io_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
		io_wr_i = 1'b1;
		io_addr_i = a;
		io_wdata_i = d;
		io_be_i = be;
		@(posedge mclk_i);
		#1;
		io_wr_i = 1'b0;
		chk("write ack", {31'h0, io_ack_o}, 32'h1);
		@(posedge mclk_i);
		#1;
	endtask

	task automatic io_rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
		io_rd_i = 1'b1;
		io_addr_i = a;
		@(posedge mclk_i);
		#1;
		io_rd_i = 1'b0;
		chk("read ack", {31'h0, io_ack_o}, 32'h1);
		chk(nm, io_rdata_o, exp);
		@(posedge mclk_i);
		#1;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		@(posedge mclk_i);
		#1;
		cfg_wr_i = 1'b0;
		@(posedge mclk_i);
		#1;
	endtask

	// counts clocks until expiry; the tick grid allows a few cycles of slack
	task automatic expect_expiry(input int exp);
		int n;
		n = 0;
		while (wdt_rst_o !== 1'b1 && n < exp + 50)
		begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk("expiry delay", (n >= exp - 4 && n <= exp + 4), 1);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		io_rd(BANK_TWO_OFS, 32'h0000_8000, "bank two reset");
		io_rd(BANK_THREE_OFS, 32'h0, "bank three reset");
		chk("wdt reset idle", {31'h0, wdt_rst_o}, 32'h0);
	endtask

	task automatic t_base();
		cfg_wr(8'h4C, 32'h0000_0300);
		cfg_wr(8'h48, 32'h0000_01A5);
		io_rd(A2, 32'h0000_8000, "bank two at new base");
		io_rd(BANK_TWO_OFS, 32'h0, "old base unmapped");
		io_wr(BANK_TWO_OFS, 32'h0, 4'hF);
		io_rd(A2, 32'h0000_8000, "stray write ignored");
		io_wr(A2, 32'h0, 4'h1);
		io_rd(A2, 32'h0000_8000, "enable lane kept");
		io_wr(A3, 32'hA5A5_0005, 4'hF);
		io_rd(A3, 32'hA5A5_0005, "bank three storage");
	endtask

	task automatic t_led();
		logic [7:0] d;
		d = 8'h82;
		post_code_i = 8'h5A;
		io_wr(A3, {24'h0, d}, 4'hF);
		chk("led before self test", {24'h0, led_o}, 32'h5A);
		for (int i = 0; i < 2; i++)
		begin
			post_done_i = 1'b1;
			io_wr(A3, {24'h0, d}, 4'hF);
			chk("led mirror", {24'h0, led_o}, {24'h0, ~d[7], post_code_i[6:3], ~d[2:0]});
			d = 8'h05;
		end
	endtask

	task automatic t_off();
		int r0;
		r0 = rst_cnt;
		io_wr(A3, 32'h7, 4'hF);
		io_wr(A2, 32'h0, 4'hF);
		repeat (400) @(posedge mclk_i);
		#1;
		chk("code seven silent", rst_cnt - r0, 32'h0);
		io_wr(A2, 32'h0000_8000, 4'hF);
		io_wr(A3, 32'h0, 4'hF);
		repeat (400) @(posedge mclk_i);
		#1;
		chk("enable high silent", rst_cnt - r0, 32'h0);
	endtask

	// every code 0..6 runs to expiry with the one-clock tick
	task automatic t_periods();
		for (int c = 0; c < 7; c++)
		begin
			// bench writes levels only; the five pins count as outputs
			io_wr(A3, c, 4'hF);
			io_wr(A2, 32'h0, 4'hF);
			expect_expiry(per_ms[c] * TK + 2);
			io_wr(A2, 32'h0000_8000, 4'hF);
			repeat (20) @(posedge mclk_i);
			#1;
			chk("pulse over", {31'h0, wdt_rst_o}, 32'h0);
		end
	endtask

	task automatic t_kick();
		logic k;
		int r0;
		k = 1'b0;
		io_wr(A3, 32'h0, 4'hF);
		io_wr(A2, 32'h0, 4'hF);
		r0 = rst_cnt;
		// toggle well inside each shortest period
		repeat (4)
		begin
			repeat (20) @(posedge mclk_i);
			#1;
			k = ~k;
			io_wr(A3, {24'h0, k, 7'h0}, 4'hF);
		end
		chk("kicked no expiry", rst_cnt - r0, 32'h0);
		expect_expiry(per_ms[0] * TK + 2);
		io_wr(A2, 32'h0000_8000, 4'hF);
	endtask

	initial
	begin
		repeat (5) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		fork
			begin
				t_reset();
				t_base();
				t_led();
				t_off();
				t_periods();
				t_kick();
			end
			begin
				// a hang counts as a mismatch and ends at the same verdict
				repeat (LIMIT) @(posedge mclk_i);
				err_count++;
			end
		join_any
		close_out();
	end
endmodule
